//--- rtl/sdu_pkg.sv
// package: constants, field layouts and carriers of the segment descriptor unit
package sdu_pkg;

  // ---------------------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------------------
  localparam int SDU_SR_COUNT       = 16;
  localparam int SDU_SLB_ENTRIES    = 4;
  localparam int SDU_GROUP_ENTRIES  = 8;
  localparam int SDU_PHYS_ADDR_BITS = 52;

  // ---------------------------------------------------------------------------
  // doublewords 0 and 1 of a segment table entry (big-endian bit b sits at 63-b)
  // ---------------------------------------------------------------------------
  localparam int SDU_STE_EFFECTIVE_SEGMENT_ID_LSB = 63 - 35;
  localparam int SDU_STE_V_POS    = 63 - 56;
  localparam int SDU_STE_T_POS    = 63 - 57;
  localparam int SDU_STE_KS_POS   = 63 - 58;
  localparam int SDU_STE_KP_POS   = 63 - 59;
  localparam int SDU_STE_N_POS    = 63 - 60;
  localparam int SDU_STE_VIRTUAL_SEGMENT_ID_LSB = 63 - 51;

  // ---------------------------------------------------------------------------
  // 32-bit segment register (big-endian bit b sits at 31-b)
  // ---------------------------------------------------------------------------
  localparam int SDU_SR_T_POS    = 31 - 0;
  localparam int SDU_SR_KS_POS   = 31 - 1;
  localparam int SDU_SR_KP_POS   = 31 - 2;
  localparam int SDU_SR_N_POS    = 31 - 3;
  localparam int SDU_SR_VIRTUAL_SEGMENT_ID_MSB = 31 - 8;
  localparam int SDU_SR_IDX_LSB  = 31 - 3;

  // ---------------------------------------------------------------------------
  // effective address and table address fields
  // ---------------------------------------------------------------------------
  localparam int SDU_EA_EFFECTIVE_SEGMENT_ID_LSB  = 63 - 35;
  localparam int SDU_EA_PAGE_LSB  = 63 - 51;
  localparam int SDU_STB_BASE_LSB = 63 - 51;
  localparam int SDU_HASH_LSB     = 63 - 56;
  localparam int SDU_ENT_LSB      = 63 - 59;

  localparam logic [31:0] SDU_SR_RESET  = 32'h0000_0000;
  localparam logic [63:0] SDU_STB_RESET = 64'h0000_0000_0000_0000;

  typedef enum logic [1:0] {
    SDU_OP_TO_SR      = 2'b00,
    SDU_OP_TO_SR_IND  = 2'b01,
    SDU_OP_FROM_SR    = 2'b10,
    SDU_OP_FROM_SR_IND = 2'b11
  } sdu_op_type;

  typedef enum logic [1:0] {
    SDU_ST_IDLE  = 2'b00,
    SDU_ST_FETCH = 2'b01,
    SDU_ST_CHECK = 2'b10
  } sdu_state_type;

  typedef struct packed {
    logic        direct_store;
    logic        supervisor_key;
    logic        user_key;
    logic        no_execute;
    logic [51:0] virtual_segment_id;
    logic [63:0] ds_info;
  } sdu_desc_type;

  typedef struct packed {
    logic        real_mode;
    logic        seg_fault;
    logic        direct_store;
    logic        supervisor_key;
    logic        user_key;
    logic        no_execute;
    logic [67:0] virtual_page_number;
    logic [63:0] ds_info;
    logic [63:0] eff_addr;
  } sdu_result_type;

endpackage

//--- rtl/sdu_top.sv
// segment descriptor unit: segment registers, table base, lookaside buffer and descriptor decode
`timescale 1ns/10ps
module sdu_top
  import sdu_pkg::*;
(
  input  wire logic           core_clk_in,
  input  wire logic           rst_n_in,
  input  wire logic           form_64_in,
  input  wire logic           supervisor_in,
  input  wire logic           instruction_relocate_in,
  input  wire logic           data_relocate_in,
  input  wire logic           xlate_valid_in,
  input  wire logic           xlate_instr_in,
  input  wire logic [63:0]    xlate_ea_in,
  output logic                xlate_busy_out,
  output logic                xlate_done_out,
  output sdu_result_type      xlate_result_out,
  input  wire logic           sr_op_valid_in,
  input  wire sdu_op_type     sr_op_in,
  input  wire logic [3:0]     sr_field_in,
  input  wire logic [31:0]    sr_index_gpr_in,
  input  wire logic [31:0]    sr_src_gpr_in,
  output logic                sr_done_out,
  output logic                sr_priv_fault_out,
  output logic [31:0]         sr_read_data_out,
  input  wire logic           stb_write_in,
  input  wire logic [63:0]    stb_write_data_in,
  output logic [63:0]         segment_table_base_out,
  output logic                machine_check_out,
  output logic                mem_req_out,
  output logic [63:0]         mem_addr_out,
  input  wire logic           mem_ack_in,
  input  wire logic [127:0]   mem_rdata_in
);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    sdu_state_type                          st;
    logic [2:0]                             ent;
    logic [63:0]                            ea;
    logic [127:0]                           line;
    logic [SDU_SR_COUNT-1:0][31:0]          sr;
    logic [63:0]                            stb;
    logic [SDU_SLB_ENTRIES-1:0]             slb_v;
    logic [SDU_SLB_ENTRIES-1:0][35:0]       slb_effective_segment_id;
    logic [SDU_SLB_ENTRIES-1:0][127:0]      slb_line;
    logic [1:0]                             slb_ptr;
    logic                                   busy;
    logic                                   done;
    sdu_result_type                         res;
    logic                                   sr_done;
    logic                                   sr_fault;
    logic [31:0]                            sr_rdata;
    logic                                   mchk;
    logic                                   mem_req;
    logic [63:0]                            mem_addr;
  } sdu_regs_type;

  sdu_regs_type regs_r;
  sdu_regs_type regs_nxt;

  // ---------------------------------------------------------------------------
  // decode functions
  // ---------------------------------------------------------------------------
  function automatic sdu_desc_type decode_ste(input logic [127:0] line);
    sdu_desc_type d;
    logic [63:0]  dw0;
    logic [63:0]  dw1;
    dw0                  = line[127:64];
    dw1                  = line[63:0];
    d.direct_store       = dw0[SDU_STE_T_POS];
    d.supervisor_key     = dw0[SDU_STE_KS_POS];
    d.user_key           = dw0[SDU_STE_KP_POS];
    d.no_execute         = dw0[SDU_STE_N_POS] & ~dw0[SDU_STE_T_POS];
    d.virtual_segment_id = dw1[63:SDU_STE_VIRTUAL_SEGMENT_ID_LSB];
    d.ds_info            = dw0[SDU_STE_T_POS] ? dw1 : 64'h0;
    return d;
  endfunction

  function automatic sdu_desc_type decode_sr(input logic [31:0] sr);
    sdu_desc_type d;
    d.direct_store       = sr[SDU_SR_T_POS];
    d.supervisor_key     = sr[SDU_SR_KS_POS];
    d.user_key           = sr[SDU_SR_KP_POS];
    d.no_execute         = sr[SDU_SR_N_POS] & ~sr[SDU_SR_T_POS];
    d.virtual_segment_id = {28'h0, sr[SDU_SR_VIRTUAL_SEGMENT_ID_MSB:0]};
    d.ds_info            = sr[SDU_SR_T_POS] ? {32'h0, sr} : 64'h0;
    return d;
  endfunction

  function automatic sdu_result_type make_result(input sdu_desc_type d,
                                                  input logic [63:0]  ea);
    sdu_result_type r;
    r.real_mode           = 1'b0;
    r.seg_fault           = 1'b0;
    r.direct_store        = d.direct_store;
    r.supervisor_key      = d.supervisor_key;
    r.user_key            = d.user_key;
    r.no_execute          = d.no_execute;
    r.virtual_page_number = {d.virtual_segment_id, ea[27:SDU_EA_PAGE_LSB]};
    r.ds_info             = d.ds_info;
    r.eff_addr            = ea;
    return r;
  endfunction

  function automatic logic [63:0] group_addr(input logic [63:0] stb,
                                             input logic [63:0] ea,
                                             input logic [2:0]  ent);
    logic [4:0] hash;
    hash = ea[SDU_EA_EFFECTIVE_SEGMENT_ID_LSB+4:SDU_EA_EFFECTIVE_SEGMENT_ID_LSB];
    return {stb[63:SDU_STB_BASE_LSB], hash, ent, 4'h0};
  endfunction

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  logic         relocate;
  logic [3:0]   sr_sel;
  logic         slb_hit;
  logic [1:0]   slb_idx;
  logic [35:0]  req_effective_segment_id;
  logic [127:0] fetched;
  logic         ent_match;

  always_comb begin
    regs_nxt = regs_r;
    regs_nxt.done    = 1'b0;
    regs_nxt.sr_done = 1'b0;
    regs_nxt.sr_fault = 1'b0;
    regs_nxt.mchk    = 1'b0;
    relocate = xlate_instr_in ? instruction_relocate_in : data_relocate_in;
    req_effective_segment_id = xlate_ea_in[63:SDU_EA_EFFECTIVE_SEGMENT_ID_LSB];
    slb_hit  = 1'b0;
    slb_idx  = 2'h0;
    for (int i = 0; i < SDU_SLB_ENTRIES; i++) begin
      if (regs_r.slb_v[i] && regs_r.slb_effective_segment_id[i] == req_effective_segment_id) begin
        slb_hit = 1'b1;
        slb_idx = 2'(i);
      end
    end
    fetched   = regs_r.line;
    ent_match = fetched[64+SDU_STE_V_POS] &&
                fetched[127:64+SDU_STE_EFFECTIVE_SEGMENT_ID_LSB] == regs_r.ea[63:SDU_EA_EFFECTIVE_SEGMENT_ID_LSB];

    // segment register moves
    sr_sel = sr_field_in;
    if (sr_op_in == SDU_OP_TO_SR_IND || sr_op_in == SDU_OP_FROM_SR_IND) begin
      sr_sel = sr_index_gpr_in[31:SDU_SR_IDX_LSB];
    end
    if (sr_op_valid_in) begin
      if (!supervisor_in) begin
        regs_nxt.sr_fault = 1'b1;
      end else begin
        regs_nxt.sr_done = 1'b1;
        if (sr_op_in == SDU_OP_TO_SR || sr_op_in == SDU_OP_TO_SR_IND) begin
          regs_nxt.sr[sr_sel] = sr_src_gpr_in;
        end else begin
          regs_nxt.sr_rdata = regs_r.sr[sr_sel];
        end
      end
    end

    // table base register
    if (stb_write_in) begin
      regs_nxt.stb      = {stb_write_data_in[63:SDU_STB_BASE_LSB], 12'h000};
      regs_nxt.slb_v    = '0;
      regs_nxt.mchk     = |stb_write_data_in[63:SDU_PHYS_ADDR_BITS];
    end

    unique case (regs_r.st)
      SDU_ST_IDLE: begin
        if (xlate_valid_in) begin
          regs_nxt.ea = xlate_ea_in;
          if (!relocate) begin
            regs_nxt.done               = 1'b1;
            regs_nxt.res                = '0;
            regs_nxt.res.real_mode      = 1'b1;
            regs_nxt.res.eff_addr       = xlate_ea_in;
          end else if (!form_64_in) begin
            regs_nxt.done = 1'b1;
            regs_nxt.res  = make_result(decode_sr(regs_r.sr[xlate_ea_in[31:SDU_SR_IDX_LSB]]),
                                        xlate_ea_in);
          end else if (slb_hit) begin
            regs_nxt.done = 1'b1;
            regs_nxt.res  = make_result(decode_ste(regs_r.slb_line[slb_idx]), xlate_ea_in);
          end else begin
            regs_nxt.st       = SDU_ST_FETCH;
            regs_nxt.busy     = 1'b1;
            regs_nxt.ent      = 3'h0;
            regs_nxt.mem_req  = 1'b1;
            regs_nxt.mem_addr = group_addr(regs_r.stb, xlate_ea_in, 3'h0);
          end
        end
      end
      SDU_ST_FETCH: begin
        if (mem_ack_in) begin
          regs_nxt.mem_req = 1'b0;
          regs_nxt.line    = mem_rdata_in;
          regs_nxt.st      = SDU_ST_CHECK;
        end
      end
      SDU_ST_CHECK: begin
        if (ent_match) begin
          regs_nxt.st                         = SDU_ST_IDLE;
          regs_nxt.busy                       = 1'b0;
          regs_nxt.done                       = 1'b1;
          regs_nxt.res                        = make_result(decode_ste(fetched), regs_r.ea);
          regs_nxt.slb_v[regs_r.slb_ptr]      = ~stb_write_in;
          regs_nxt.slb_effective_segment_id[regs_r.slb_ptr]   = regs_r.ea[63:SDU_EA_EFFECTIVE_SEGMENT_ID_LSB];
          regs_nxt.slb_line[regs_r.slb_ptr]   = fetched;
          regs_nxt.slb_ptr                    = regs_r.slb_ptr + 2'h1;
        end else if (regs_r.ent == 3'(SDU_GROUP_ENTRIES - 1)) begin
          regs_nxt.st              = SDU_ST_IDLE;
          regs_nxt.busy            = 1'b0;
          regs_nxt.done            = 1'b1;
          regs_nxt.res             = '0;
          regs_nxt.res.seg_fault   = 1'b1;
          regs_nxt.res.eff_addr    = regs_r.ea;
        end else begin
          regs_nxt.st       = SDU_ST_FETCH;
          regs_nxt.ent      = regs_r.ent + 3'h1;
          regs_nxt.mem_req  = 1'b1;
          regs_nxt.mem_addr = group_addr(regs_r.stb, regs_r.ea, regs_r.ent + 3'h1);
        end
      end
      default: begin
        regs_nxt.st = SDU_ST_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      regs_r          <= '0;
      regs_r.st       <= SDU_ST_IDLE;
      regs_r.stb      <= SDU_STB_RESET;
      regs_r.sr       <= {SDU_SR_COUNT{SDU_SR_RESET}};
    end else begin
      regs_r <= regs_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  assign xlate_busy_out         = regs_r.busy;
  assign xlate_done_out         = regs_r.done;
  assign xlate_result_out       = regs_r.res;
  assign sr_done_out            = regs_r.sr_done;
  assign sr_priv_fault_out      = regs_r.sr_fault;
  assign sr_read_data_out       = regs_r.sr_rdata;
  assign segment_table_base_out = regs_r.stb;
  assign machine_check_out      = regs_r.mchk;
  assign mem_req_out            = regs_r.mem_req;
  assign mem_addr_out           = regs_r.mem_addr;

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  a_priv_move_fault: assert property (
    sr_op_valid_in && !supervisor_in |=> sr_priv_fault_out && !sr_done_out)
    else $error("user mode segment register move not refused");

  a_sr_write_read: assert property (
    sr_op_valid_in && supervisor_in && sr_op_in == SDU_OP_TO_SR ##1
    sr_op_valid_in && supervisor_in && sr_op_in == SDU_OP_FROM_SR &&
    sr_field_in == $past(sr_field_in) |=> sr_read_data_out == $past(sr_src_gpr_in, 2))
    else $error("segment register read back differs from write");

  a_real_bypass: assert property (
    xlate_valid_in && !xlate_busy_out && !data_relocate_in && !xlate_instr_in
    |=> xlate_done_out && xlate_result_out.real_mode && !mem_req_out &&
        xlate_result_out.eff_addr == $past(xlate_ea_in))
    else $error("real mode access not bypassed");

  a_sr32_decode: assert property (
    xlate_valid_in && !xlate_busy_out && !form_64_in &&
    (xlate_instr_in ? instruction_relocate_in : data_relocate_in)
    |=> xlate_done_out && xlate_result_out.virtual_page_number[39:16] ==
        $past(regs_r.sr[xlate_ea_in[31:28]][23:0]) &&
        xlate_result_out.direct_store == $past(regs_r.sr[xlate_ea_in[31:28]][31]))
    else $error("segment register decode wrong");

  a_base_reserved: assert property (
    segment_table_base_out[11:0] == 12'h000)
    else $error("table base reserved bits not zero");

  a_high_bits_check: assert property (
    stb_write_in && stb_write_data_in[63:52] != 12'h000 |=> machine_check_out)
    else $error("machine check missing for unimplemented base bits");

  a_group_start: assert property (
    $rose(mem_req_out) && $past(regs_r.st) == SDU_ST_IDLE
    |-> mem_addr_out[6:0] == 7'h00 &&
        mem_addr_out[63:12] == segment_table_base_out[63:12])
    else $error("search does not start at group entry zero");

  a_req_holds: assert property (
    mem_req_out && !mem_ack_in |=> mem_req_out && $stable(mem_addr_out))
    else $error("fetch request dropped before acknowledge");

  a_search_fault: assert property (
    xlate_done_out && xlate_result_out.seg_fault |-> $past(regs_r.ent) == 3'h7)
    else $error("segment fault before the whole group was searched");

  a_page_number: assert property (
    xlate_done_out && !xlate_result_out.real_mode && !xlate_result_out.seg_fault
    |-> xlate_result_out.virtual_page_number[15:0] == xlate_result_out.eff_addr[27:12])
    else $error("page index not placed below virtual segment id");

  c_real_mode: cover property (xlate_done_out && xlate_result_out.real_mode);
  c_table_hit: cover property (regs_r.st == SDU_ST_CHECK && ent_match);
  c_seg_fault: cover property (xlate_done_out && xlate_result_out.seg_fault);
  c_slb_hit: cover property (xlate_valid_in && !xlate_busy_out && form_64_in && slb_hit);

endmodule

//--- sim/sdu_mem_model.sv
// memory model: answers entry fetches from one segment table group
`timescale 1ns/10ps
module sdu_mem_model (
  input  wire logic         core_clk_in,
  input  wire logic         rst_n_in,
  input  wire logic         mem_req_in,
  input  wire logic [63:0]  mem_addr_in,
  output logic              mem_ack_out,
  output logic [127:0]      mem_rdata_out
);
  logic [127:0] tbl [0:7];
  int           lat = 0;
  int           cnt;
  // one ack per request after lat idle cycles; data is scrambled outside the ack
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mem_ack_out   <= 1'b0;
      mem_rdata_out <= 128'h0;
      cnt           <= 0;
    end else if (mem_ack_out) begin
      mem_ack_out   <= 1'b0;
      mem_rdata_out <= ~mem_rdata_out;
      cnt           <= 0;
    end else if (mem_req_in && cnt >= lat) begin
      mem_ack_out   <= 1'b1;
      mem_rdata_out <= tbl[mem_addr_in[6:4]];
    end else if (mem_req_in) begin
      cnt <= cnt + 1;
    end
  end
endmodule

//--- sim/sdu_top_bench.sv
// testbench: segment register moves, table search and descriptor decode
`timescale 1ns/10ps
module sdu_top_bench import sdu_pkg::*;;
  localparam logic [31:0] SRV = 32'h6f12_3456;
  localparam logic [31:0] SRD = 32'hc0ab_cdef;
  localparam logic [35:0] E1  = 36'h0_0000_0123;
  localparam logic [51:0] V1  = 52'hf_edcb_a987_6543;
  logic clk = 0, rst_n = 0, f64 = 0, sup = 1, irel = 0, drel = 0, xv = 0, xi = 0;
  logic sv = 0, sbw = 0, busy, done, srd, srf, mc, mreq, mack;
  logic [63:0] xea = 0, sbd = 0, base, maddr, last_addr;
  logic [31:0] sidx = 0, ssrc = 0, srdat;
  logic [3:0] sf = 0;
  logic [127:0] mdat;
  sdu_op_type sop = SDU_OP_TO_SR;
  sdu_result_type res;
  int n_errors = 0, n_tests = 0, acks = 0, cyc;

  sdu_top DUT (.core_clk_in(clk), .rst_n_in(rst_n), .form_64_in(f64), .supervisor_in(sup),
    .instruction_relocate_in(irel), .data_relocate_in(drel), .xlate_valid_in(xv),
    .xlate_instr_in(xi), .xlate_ea_in(xea), .xlate_busy_out(busy), .xlate_done_out(done),
    .xlate_result_out(res), .sr_op_valid_in(sv), .sr_op_in(sop), .sr_field_in(sf),
    .sr_index_gpr_in(sidx), .sr_src_gpr_in(ssrc), .sr_done_out(srd),
    .sr_priv_fault_out(srf), .sr_read_data_out(srdat), .stb_write_in(sbw),
    .stb_write_data_in(sbd), .segment_table_base_out(base), .machine_check_out(mc),
    .mem_req_out(mreq), .mem_addr_out(maddr), .mem_ack_in(mack), .mem_rdata_in(mdat));
  sdu_mem_model mem (.core_clk_in(clk), .rst_n_in(rst_n), .mem_req_in(mreq),
    .mem_addr_in(maddr), .mem_ack_out(mack), .mem_rdata_out(mdat));

  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (mreq && mack) begin
      acks      <= acks + 1;
      last_addr <= maddr;
    end
  end

  // ---------------------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic srop(input sdu_op_type op, input logic [3:0] f, input logic [31:0] idx,
                      input logic [31:0] src, input logic s);
    @(posedge clk);
    sv <= 1'b1; sop <= op; sf <= f; sidx <= idx; ssrc <= src; sup <= s;
    @(posedge clk);
    sv <= 1'b0;
    #1;
  endtask
  task automatic bw(input logic [63:0] d);
    @(posedge clk);
    sbw <= 1'b1; sbd <= d;
    @(posedge clk);
    sbw <= 1'b0;
    #1;
  endtask
  task automatic xl(input logic f, input logic r, input logic i, input logic [63:0] ea);
    @(posedge clk);
    xv <= 1'b1; f64 <= f; irel <= r; drel <= r; xi <= i; xea <= ea;
    @(posedge clk);
    xv <= 1'b0;
    #1;
    cyc = 0;
    while (done !== 1'b1 && cyc < 300) begin
      @(posedge clk);
      #1;
      cyc++;
    end
    if (cyc >= 300) begin
      chk(1'b0, 1'b1, "translation timeout");
      end_sim;
    end
  endtask
  function automatic logic [63:0] dw0(input logic [35:0] e, input logic [4:0] b);
    return {e, 20'hfffff, b, 3'b111};
  endfunction

  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task automatic t_sr;
    srop(SDU_OP_FROM_SR_IND, 4'h0, 32'h5000_0000, 32'h0, 1'b1);
    chk(srdat, 32'h0, "register after reset");
    srop(SDU_OP_TO_SR_IND, 4'h0, 32'h5fff_ffff, SRV, 1'b1);
    chk({srf, srd}, 2'b01, "indirect write");
    srop(SDU_OP_TO_SR, 4'hf, 32'h0, SRD, 1'b1);
    srop(SDU_OP_FROM_SR, 4'h5, 32'h0, 32'h0, 1'b1);
    chk(srdat, SRV, "direct read");
    srop(SDU_OP_TO_SR, 4'h5, 32'h0, 32'h0, 1'b0);
    chk({srf, srd}, 2'b10, "user write refused");
    srop(SDU_OP_FROM_SR_IND, 4'h0, 32'h5000_0000, 32'h0, 1'b1);
    chk(srdat, SRV, "value kept after refusal");
    // back-to-back write then read of one register
    @(posedge clk);
    sv <= 1'b1; sop <= SDU_OP_TO_SR; sf <= 4'h9; ssrc <= 32'h1357_9bdf; sup <= 1'b1;
    @(posedge clk);
    sop <= SDU_OP_FROM_SR;
    @(posedge clk);
    sv <= 1'b0;
    #1;
    chk(srdat, 32'h1357_9bdf, "back to back move");
  endtask
  task automatic t_x32;
    xl(1'b0, 1'b1, 1'b0, 64'h0000_0000_5abc_d123);
    chk(res[201:196], 6'b000110, "register keys");
    chk(res.virtual_page_number, {28'h0, SRV[23:0], 16'habcd}, "register page number");
    xl(1'b0, 1'b1, 1'b1, 64'h0000_0000_f000_0000);
    chk({res.direct_store, res.ds_info}, {1'b1, 32'h0, SRD}, "register direct-store");
    xl(1'b0, 1'b0, 1'b0, 64'h0000_0000_5abc_d123);
    chk({res.real_mode, res.eff_addr}, {1'b1, 64'h5abc_d123}, "real addressing");
  endtask
  task automatic t_base;
    bw(64'h0010_0000_0012_3000);
    chk(mc, 1'b1, "wide base flagged");
    bw(64'h0000_0000_0012_3fff);
    chk({mc, base}, {1'b0, 64'h0000_0000_0012_3000}, "base reserved bits");
  endtask
  task automatic t_x64;
    xl(1'b1, 1'b1, 1'b0, 64'h0000_0012_3456_7abc);
    chk(res[201:196], 6'b000101, "entry keys");
    chk(res.virtual_page_number, {V1, 16'h4567}, "entry page number");
    chk({acks[7:0], last_addr}, {8'd3, 64'h0000_0000_0012_31a0}, "group walk");
    xl(1'b1, 1'b1, 1'b0, 64'h0000_0012_3456_7abc);
    chk({cyc[7:0], acks[7:0], res.virtual_page_number}, {16'h0003, V1, 16'h4567}, "hit");
    mem.lat = 2;
    xl(1'b1, 1'b1, 1'b1, 64'h0000_0022_3000_0000);
    chk(res[201:196], 6'b001100, "direct-store entry keys");
    chk(res.ds_info, 64'h1122_3344_5566_7788, "controller data");
    xl(1'b1, 1'b1, 1'b0, 64'h0000_0032_3000_0000);
    chk({res.seg_fault, acks[7:0]}, {1'b1, 8'd12}, "no match in group");
  endtask

  initial begin
    mem.tbl[0] = {dw0(36'h0_0000_0223, 5'b11100), 64'h1122_3344_5566_7788};
    mem.tbl[1] = {dw0(E1, 5'b00111), V1, 12'h000};
    mem.tbl[2] = {dw0(E1, 5'b10101), V1, 12'hfff};
    for (int k = 3; k < 8; k++) mem.tbl[k] = 128'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk({done, busy, mreq, mc, base}, 68'h0, "idle after reset");
    t_sr();
    t_x32();
    t_base();
    t_x64();
    end_sim;
  end
endmodule
